// *** hw/asa_pkg.sv ***
// Constants, types and helpers for the async serial adapter
// How it works
// - Data write captures byte, clears tx empty
// - Idle transmitter takes next queued byte, sets empty once the queue drains
// - Next byte follows last stop bit directly
// - Finished character loads empty holding, sets full
// - Data read clears full unless an overrun is pending, keeps byte
// - Full holding register blocks further loads
// - Write-only control register at select low
// - Bits 1:0 pick divide or master reset
// - Master reset clears status and both shifters
// - Bits 4:2 pick length, parity, stop bits
// - Format changes act at once
// - Bits 6:5 drive request, tx interrupt, break
// - Bit 7 enables receive side interrupts
// - Read-only status register at select low
// - Fixed status bit positions
// - Carrier input high shows receiver empty
// - Carrier loss latches, status-then-data read clears
// - Clear-to-send mirrored, high inhibits tx empty
// - Missing first stop sets framing error
// - Overrun shown after read, data read clears
// - Parity error per character, off without parity
// - Seven-bit modes zero bit 7, LSB first
// - Status bit 7 mirrors interrupt output
// - Launch on tx clock fall, sample on rise
// - Start bit confirmed after half bit in divide 16 and 64, not in divide 1
package asa_pkg;
  localparam logic [7:0] ASA_CTRL_RESET = 8'h03;
  localparam int ASA_CB_DIV = 0;
  localparam int ASA_CB_FMT = 2;
  localparam int ASA_CB_TXC = 5;
  localparam int ASA_CB_RIE = 7;
  localparam int ASA_SB_RXF = 0;
  localparam int ASA_SB_TXE = 1;
  localparam int ASA_SB_DCD = 2;
  localparam int ASA_SB_CTS = 3;
  localparam int ASA_SB_FE = 4;
  localparam int ASA_SB_OVR = 5;
  localparam int ASA_SB_PE = 6;
  localparam int ASA_SB_IRQ = 7;
  localparam logic [1:0] ASA_DIV1 = 2'h0;
  localparam logic [1:0] ASA_DIV16 = 2'h1;
  localparam logic [1:0] ASA_DIV64 = 2'h2;
  localparam logic [1:0] ASA_MRESET = 2'h3;
  localparam logic [1:0] ASA_TXC_QUIET = 2'h0;
  localparam logic [1:0] ASA_TXC_INT = 2'h1;
  localparam logic [1:0] ASA_TXC_RTS_HI = 2'h2;
  localparam logic [1:0] ASA_TXC_BREAK = 2'h3;
  localparam logic [5:0] ASA_LAST16 = 6'h0F;
  localparam logic [5:0] ASA_LAST64 = 6'h3F;
  localparam logic [5:0] ASA_HALF16 = 6'h07;
  localparam logic [5:0] ASA_HALF64 = 6'h1F;
  localparam logic [2:0] ASA_LAST7 = 3'h6;
  localparam logic [2:0] ASA_LAST8 = 3'h7;
  localparam int ASA_FIFO_DEPTH = 8;

  typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP1, TX_STOP2} asa_tx_st_t;
  typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP} asa_rx_st_t;

  typedef struct packed {
    logic cs0;
    logic cs1;
    logic cs2_n;
    logic register_select;
    logic rw;
    logic e;
    logic [7:0] data;
  } asa_bus_t;

  typedef struct packed {
    logic rxd;
    logic rx_clk;
    logic tx_clk;
    logic cts_n;
    logic dcd_n;
  } asa_modem_t;

  typedef struct packed {
    logic eight;
    logic par_en;
    logic par_odd;
    logic stop2;
  } asa_frame_t;

  typedef struct packed {
    logic [5:0] cnt;
    logic half;
  } asa_timer_t;

  typedef struct packed {
    logic [7:0] ctrl;
    logic [7:0] rx_hold;
    logic rx_full;
    logic fe;
    logic pe;
    logic ovr;
    logic ovr_pend;
    logic dcd_lat;
    logic dcd_armed;
    logic dcd_prev;
    logic e_prev;
    logic txc_prev;
    logic rxc_prev;
    logic irq;
    logic [7:0] dout;
    logic doe;
    logic rts_n;
    logic tx_bit;
    logic tx_line;
    asa_tx_st_t tx_st;
    logic [7:0] tx_sh;
    logic [2:0] tx_cnt;
    logic tx_par;
    asa_rx_st_t rx_st;
    logic [7:0] rx_sh;
    logic [2:0] rx_cnt;
    logic rx_par;
  } asa_state_t;

  function automatic asa_frame_t asa_decode(input logic [2:0] f);
    asa_frame_t r;
    r.eight = f[2];
    r.par_en = ~f[2] | f[1];
    r.par_odd = f[0];
    r.stop2 = (~f[2] & ~f[1]) | (f[2] & ~f[1] & ~f[0]);
    return r;
  endfunction

  function automatic logic [5:0] asa_limit(input logic [1:0] div, input logic half);
    logic [5:0] r;
    r = 6'h00;
    if (div == ASA_DIV16) begin
      r = half ? ASA_HALF16 : ASA_LAST16;
    end else if (div == ASA_DIV64) begin
      r = half ? ASA_HALF64 : ASA_LAST64;
    end
    return r;
  endfunction
endpackage

// *** hw/asa_bit_timer.sv ***
// Bit period divider for the serial clocks
`timescale 1ns/100ps
module asa_bit_timer (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic clr,
  input wire logic tick,
  input wire logic restart,
  input wire logic [1:0] div,
  output logic strobe
);
  import asa_pkg::*;
  asa_timer_t q, d;
  logic [5:0] limit;

  always_comb begin
    d = q;
    strobe = 1'b0;
    limit = asa_limit(div, q.half);
    if (clr) begin
      d = '0;
    end else if (restart) begin
      // Half bit first so later strobes land mid-bit
      d.cnt = 6'h00;
      d.half = 1'b1;
    end else if (tick) begin
      if (q.cnt >= limit) begin
        strobe = 1'b1;
        d.cnt = 6'h00;
        d.half = 1'b0;
      end else begin
        d.cnt = q.cnt + 6'h01;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end
endmodule // asa_bit_timer

// *** hw/asa_fifo.sv ***
// Transmit byte queue with valid and ready on both sides
`timescale 1ns/100ps
module asa_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic clr,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
  } asa_fifo_st_t;
  asa_fifo_st_t q, d;
  logic push, pop;

  assign in_ready = (q.cnt != (AW+1)'(DEPTH));
  assign out_valid = (q.cnt != '0);
  assign out_data = q.mem[q.rp];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_comb begin
    d = q;
    if (clr) begin
      d.wp = '0;
      d.rp = '0;
      d.cnt = '0;
    end else begin
      if (push) begin
        d.mem[q.wp] = in_data;
        d.wp = (q.wp == AW'(DEPTH - 1)) ? '0 : q.wp + AW'(1);
      end
      if (pop) begin
        d.rp = (q.rp == AW'(DEPTH - 1)) ? '0 : q.rp + AW'(1);
      end
      d.cnt = q.cnt + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end
endmodule // asa_fifo

// *** hw/asa_adapter.sv ***
// Async serial adapter: bus registers, transmitter and receiver
`timescale 1ns/100ps
module asa_adapter (
  input wire logic mclk,
  input wire logic rstn,
  input wire asa_pkg::asa_bus_t bus,
  input wire asa_pkg::asa_modem_t modem,
  output logic [7:0] data_drive,
  output logic data_en,
  output logic tx_line,
  output logic rts_n,
  output logic irq_low_en
);
  import asa_pkg::*;

  asa_state_t q, d;
  asa_frame_t frm;
  logic sel, e_fall, wr_data, wr_ctrl, rd_data, rd_stat;
  logic mres, tx_tick, rx_tick, tx_strobe, rx_strobe, rx_restart, rx_clr;
  logic fifo_in_ready, fifo_valid, fifo_pop;
  logic [7:0] fifo_data, stat, rx_byte;
  logic txe_shown, rxf_shown, dcd_rise, tx_take;
  logic [2:0] tx_last, rx_last;

  // Bus strobe sampled on mclk; accesses act on its falling edge
  assign sel = bus.cs0 && bus.cs1 && !bus.cs2_n;
  assign e_fall = q.e_prev && !bus.e && sel;
  assign wr_data = e_fall && bus.register_select && !bus.rw;
  assign wr_ctrl = e_fall && !bus.register_select && !bus.rw;
  assign rd_data = e_fall && bus.register_select && bus.rw;
  assign rd_stat = e_fall && !bus.register_select && bus.rw;

  assign mres = (q.ctrl[ASA_CB_DIV +: 2] == ASA_MRESET);
  assign frm = asa_decode(q.ctrl[ASA_CB_FMT +: 3]);
  assign tx_last = frm.eight ? ASA_LAST8 : ASA_LAST7;
  assign rx_last = frm.eight ? ASA_LAST8 : ASA_LAST7;
  assign tx_tick = q.txc_prev && !modem.tx_clk;
  assign rx_tick = !q.rxc_prev && modem.rx_clk;
  assign rx_clr = mres || modem.dcd_n;
  assign dcd_rise = !q.dcd_prev && modem.dcd_n;

  // Status view; empty inhibited by clear-to-send, full masked by carrier loss
  assign txe_shown = !fifo_valid && !modem.cts_n;
  assign rxf_shown = q.rx_full && !modem.dcd_n;
  always_comb begin
    stat = 8'h00;
    stat[ASA_SB_RXF] = rxf_shown;
    stat[ASA_SB_TXE] = txe_shown;
    stat[ASA_SB_DCD] = q.dcd_lat || modem.dcd_n;
    stat[ASA_SB_CTS] = modem.cts_n;
    stat[ASA_SB_FE] = q.fe;
    stat[ASA_SB_OVR] = q.ovr;
    stat[ASA_SB_PE] = q.pe;
    stat[ASA_SB_IRQ] = q.irq;
  end

  assign rx_byte = frm.eight ? q.rx_sh : {1'b0, q.rx_sh[7:1]};
  assign tx_take = tx_strobe && (q.tx_st == TX_IDLE || (q.tx_st == TX_STOP1 && !frm.stop2)
                   || q.tx_st == TX_STOP2);
  assign fifo_pop = tx_take && !mres;

  asa_fifo #(
    .WIDTH(8),
    .DEPTH(ASA_FIFO_DEPTH)
  ) u_fifo (
    .mclk(mclk),
    .rstn(rstn),
    .clr(mres),
    .in_valid(wr_data),
    .in_ready(fifo_in_ready),
    .in_data(bus.data),
    .out_valid(fifo_valid),
    .out_ready(fifo_pop),
    .out_data(fifo_data)
  );

  asa_bit_timer u_tx_timer (
    .mclk(mclk),
    .rstn(rstn),
    .clr(mres),
    .tick(tx_tick),
    .restart(1'b0),
    .div(q.ctrl[ASA_CB_DIV +: 2]),
    .strobe(tx_strobe)
  );

  asa_bit_timer u_rx_timer (
    .mclk(mclk),
    .rstn(rstn),
    .clr(rx_clr),
    .tick(rx_tick),
    .restart(rx_restart),
    .div(q.ctrl[ASA_CB_DIV +: 2]),
    .strobe(rx_strobe)
  );

  always_comb begin
    d = q;
    rx_restart = 1'b0;
    d.e_prev = bus.e;
    d.txc_prev = modem.tx_clk;
    d.rxc_prev = modem.rx_clk;
    d.dcd_prev = modem.dcd_n;

    // Read data stays on the pins while the strobe is high
    d.doe = bus.e && sel && bus.rw;
    if (bus.e && sel && bus.rw) begin
      d.dout = bus.register_select ? q.rx_hold : stat;
    end

    if (wr_ctrl) begin
      d.ctrl = bus.data;
    end

    // Transmitter, one step per bit boundary
    if (tx_strobe) begin
      case (q.tx_st)
        TX_START: begin
          d.tx_bit = q.tx_sh[0];
          d.tx_par = q.tx_sh[0];
          d.tx_sh = {1'b0, q.tx_sh[7:1]};
          d.tx_cnt = 3'h0;
          d.tx_st = TX_DATA;
        end
        TX_DATA: begin
          if (q.tx_cnt == tx_last) begin
            if (frm.par_en) begin
              d.tx_bit = q.tx_par ^ frm.par_odd;
              d.tx_st = TX_PAR;
            end else begin
              d.tx_bit = 1'b1;
              d.tx_st = TX_STOP1;
            end
          end else begin
            d.tx_bit = q.tx_sh[0];
            d.tx_par = q.tx_par ^ q.tx_sh[0];
            d.tx_sh = {1'b0, q.tx_sh[7:1]};
            d.tx_cnt = q.tx_cnt + 3'h1;
          end
        end
        TX_PAR: begin
          d.tx_bit = 1'b1;
          d.tx_st = TX_STOP1;
        end
        TX_STOP1: begin
          if (frm.stop2) begin
            d.tx_st = TX_STOP2;
          end
        end
        TX_IDLE, TX_STOP2: begin
          d.tx_bit = 1'b1;
        end
        default: begin
          d.tx_st = TX_IDLE;
        end
      endcase
      if (tx_take) begin
        // Start bit of the next queued byte follows the stop bit at once
        if (fifo_valid) begin
          d.tx_sh = fifo_data;
          d.tx_bit = 1'b0;
          d.tx_st = TX_START;
        end else begin
          d.tx_bit = 1'b1;
          d.tx_st = TX_IDLE;
        end
      end
    end

    // Receiver, one step per mid-bit sample
    if (rx_tick && q.rx_st == RX_IDLE && !modem.rxd) begin
      if (q.ctrl[ASA_CB_DIV +: 2] == ASA_DIV1) begin
        d.rx_st = RX_DATA;
        d.rx_cnt = 3'h0;
        d.rx_par = 1'b0;
      end else begin
        rx_restart = 1'b1;
        d.rx_st = RX_START;
      end
    end else if (rx_strobe) begin
      case (q.rx_st)
        RX_START: begin
          // Glitch shorter than half a bit is dropped
          d.rx_st = modem.rxd ? RX_IDLE : RX_DATA;
          d.rx_cnt = 3'h0;
          d.rx_par = 1'b0;
        end
        RX_DATA: begin
          d.rx_sh = {modem.rxd, q.rx_sh[7:1]};
          d.rx_par = q.rx_par ^ modem.rxd;
          if (q.rx_cnt == rx_last) begin
            d.rx_st = frm.par_en ? RX_PAR : RX_STOP;
          end else begin
            d.rx_cnt = q.rx_cnt + 3'h1;
          end
        end
        RX_PAR: begin
          d.rx_par = q.rx_par ^ modem.rxd ^ frm.par_odd;
          d.rx_st = RX_STOP;
        end
        RX_STOP: begin
          d.rx_st = RX_IDLE;
          if (!q.rx_full) begin
            d.rx_hold = rx_byte;
            d.rx_full = 1'b1;
            d.fe = !modem.rxd;
            d.pe = frm.par_en && q.rx_par;
          end else begin
            d.ovr_pend = 1'b1;
          end
        end
        default: begin
          d.rx_st = RX_IDLE;
        end
      endcase
    end

    // Data read: overrun waits behind the valid byte it follows
    if (rd_data) begin
      if (q.ovr_pend) begin
        d.ovr = 1'b1;
        d.ovr_pend = 1'b0;
      end else begin
        d.ovr = 1'b0;
        d.rx_full = 1'b0;
      end
      if (q.dcd_armed) begin
        d.dcd_lat = 1'b0;
        d.dcd_armed = 1'b0;
      end
    end
    if (rd_stat && q.dcd_lat) begin
      d.dcd_armed = 1'b1;
    end
    // A late overrun still wins over the clearing read
    if (rx_strobe && q.rx_st == RX_STOP && q.rx_full && !rx_clr) begin
      d.ovr_pend = 1'b1;
    end
    if (dcd_rise) begin
      d.dcd_lat = 1'b1;
    end

    if (modem.dcd_n) begin
      d.rx_st = RX_IDLE;
    end
    if (mres) begin
      d.rx_full = 1'b0;
      d.fe = 1'b0;
      d.pe = 1'b0;
      d.ovr = 1'b0;
      d.ovr_pend = 1'b0;
      d.dcd_lat = 1'b0;
      d.dcd_armed = 1'b0;
      d.tx_st = TX_IDLE;
      d.rx_st = RX_IDLE;
      d.tx_bit = 1'b1;
    end

    d.irq = (txe_shown && q.ctrl[ASA_CB_TXC +: 2] == ASA_TXC_INT) ||
            (q.ctrl[ASA_CB_RIE] && (rxf_shown || q.ovr || q.dcd_lat));
    d.rts_n = (q.ctrl[ASA_CB_TXC +: 2] == ASA_TXC_RTS_HI);
    d.tx_line = (q.ctrl[ASA_CB_TXC +: 2] == ASA_TXC_BREAK) ? 1'b0 : d.tx_bit;
  end

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      q <= '0;
      q.ctrl <= ASA_CTRL_RESET;
      q.tx_bit <= 1'b1;
      q.tx_line <= 1'b1;
      q.tx_st <= TX_IDLE;
      q.rx_st <= RX_IDLE;
    end else begin
      q <= d;
    end
  end

  assign data_drive = q.dout;
  assign data_en = q.doe;
  assign tx_line = q.tx_line;
  assign rts_n = q.rts_n;
  assign irq_low_en = q.irq;

  wr_data_capture_a: assert property (@(posedge mclk) disable iff (!rstn)
    (wr_data && fifo_in_ready && !mres) |=> fifo_valid)
    else $error("Written byte did not reach the queue");

  rd_clears_full_a: assert property (@(posedge mclk) disable iff (!rstn)
    (rd_data && q.rx_full && !q.ovr_pend) |=> (!q.rx_full && $stable(q.rx_hold)))
    else $error("Data read did not clear full or changed the byte");

  full_blocks_load_a: assert property (@(posedge mclk) disable iff (!rstn)
    (q.rx_full && !rd_data && !mres) |=> $stable(q.rx_hold))
    else $error("Holding register changed while full");

  mreset_clears_a: assert property (@(posedge mclk) disable iff (!rstn)
    mres |=> (!q.rx_full && !q.ovr && !q.dcd_lat && q.tx_st == TX_IDLE))
    else $error("Master reset left status or transmitter set");

  rts_follows_ctrl_a: assert property (@(posedge mclk) disable iff (!rstn)
    ##1 (rts_n == ($past(q.ctrl[ASA_CB_TXC +: 2]) == ASA_TXC_RTS_HI)))
    else $error("Request-to-send does not follow control bits");

  break_space_a: assert property (@(posedge mclk) disable iff (!rstn)
    (q.ctrl[ASA_CB_TXC +: 2] == ASA_TXC_BREAK) |=> !tx_line)
    else $error("Break selected but line not at space");

  cts_inhibit_a: assert property (@(posedge mclk) disable iff (!rstn)
    modem.cts_n |-> (!stat[ASA_SB_TXE] && stat[ASA_SB_CTS]))
    else $error("Transmit empty shown while clear-to-send high");

  dcd_masks_full_a: assert property (@(posedge mclk) disable iff (!rstn)
    modem.dcd_n |-> (!stat[ASA_SB_RXF] && stat[ASA_SB_DCD]))
    else $error("Full shown while carrier input high");

  rx_irq_raise_a: assert property (@(posedge mclk) disable iff (!rstn)
    (q.ctrl[ASA_CB_RIE] && q.ovr) |=> irq_low_en)
    else $error("Enabled overrun did not raise interrupt");

  seven_bit_zero_a: assert property (@(posedge mclk) disable iff (!rstn)
    ($rose(q.rx_full) && !$past(frm.eight)) |-> !q.rx_hold[7])
    else $error("Seven-bit character kept bit 7");
endmodule // asa_adapter

// *** bench/asa_modem_model.sv ***
// Modem side model: serial clocks, frame sender and frame catcher
`timescale 1ns/100ps
module asa_modem_model (
  input wire logic tx_line,
  output asa_pkg::asa_modem_t modem
);
  import asa_pkg::*;
  logic txc = 1'b1;
  logic rxc = 1'b1;
  logic rxd = 1'b1;
  logic cts_n = 1'b0;
  logic dcd_n = 1'b0;
  logic [11:0] cap = 12'hFFF;
  int cnt = 0;
  int idle = 0;
  int flen = 10;
  logic [11:0] frames[$];
  int gaps[$];

  // Baud clocks run free, phase unrelated to mclk
  always #200 txc = ~txc;
  always #180 rxc = ~rxc;
  assign modem = {rxd, rxc, txc, cts_n, dcd_n};

  // Catch frames on rising transmit clock, idle bits counted between them
  always @(posedge txc) begin
    if (cnt == 0 && tx_line !== 1'b0) begin
      idle++;
    end else begin
      cap[cnt] = tx_line;
      cnt++;
      if (cnt == flen) begin
        frames.push_back(cap);
        gaps.push_back(idle);
        cap = 12'hFFF;
        idle = 0;
        cnt = 0;
      end
    end
  end

  // Bits change on falling receive clock so the rising edge sees them settled
  task automatic send(input logic [11:0] bits, input int n);
    for (int i = 0; i < n; i++) begin
      @(negedge rxc);
      rxd = bits[i];
    end
    @(negedge rxc);
    rxd = 1'b1;
  endtask
endmodule // asa_modem_model

// *** bench/tb_asa_adapter.sv ***
// Self-checking bench for the async serial adapter
`timescale 1ns/100ps
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin errors++; \
  $display("[FAIL] t=%0t got=%h exp=%h", $time, (a), (b)); end end
module tb_asa_adapter;
  import asa_pkg::*;
  logic mclk;
  logic rstn;
  asa_bus_t bus;
  asa_modem_t modem;
  logic [7:0] data_drive;
  logic data_en;
  logic tx_line;
  logic rts_n;
  logic irq_low_en;
  int errors = 0;
  int checks_done = 0;
  logic [7:0] st, rv, d0, d1;
  logic [11:0] e0, e1;
  logic [2:0] f;
  int n, k;
  logic [4:0] rx_tab [5] = '{5'h14, 5'h0C, 5'h1A, 5'h11, 5'h02};

  asa_adapter dut_u (.mclk(mclk), .rstn(rstn), .bus(bus), .modem(modem), .data_drive(data_drive),
    .data_en(data_en), .tx_line(tx_line), .rts_n(rts_n), .irq_low_en(irq_low_en));
  asa_modem_model model (.tx_line(tx_line), .modem(modem));

  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end

  task automatic close_out;
    $display("errors=%0d checks_done=%0d", errors, checks_done);
    if (errors == 0 && checks_done > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // One strobed access; address held until after the strobe falls
  task automatic acc(input logic rs, input logic rw, input logic [7:0] wd, output logic [7:0] rdv);
    @(posedge mclk);
    #2 bus = '{1'b1, 1'b1, 1'b0, rs, rw, 1'b1, wd};
    @(posedge mclk);
    #2 rdv = data_drive;
    bus.e = 1'b0;
    @(posedge mclk);
    #2 bus.cs0 = 1'b0;
  endtask

  task automatic wr(input logic rs, input logic [7:0] wd);
    logic [7:0] dummy;
    acc(rs, 1'b0, wd, dummy);
  endtask

  task automatic ctl(input logic [7:0] v);
    wr(1'b0, v);
  endtask

  task automatic wait_full;
    logic [7:0] s = 8'h00;
    for (int i = 0; i < 400 && s[0] !== 1'b1; i++) acc(1'b0, 1'b1, 8'h00, s);
    if (s[0] !== 1'b1) begin
      errors++;
      close_out();
    end
  endtask

  // Whole frame, start bit at index 0, data LSB first, unused top bits mark
  function automatic logic [11:0] frame_of(input logic [2:0] fm, input logic [7:0] d, input logic bp,
      input logic bs, output int len);
    logic [11:0] r;
    logic p;
    int dl;
    int j;
    r = 12'hFFF;
    r[0] = 1'b0;
    dl = fm[2] ? 8 : 7;
    p = fm[0];
    for (j = 0; j < dl; j++) begin
      r[1 + j] = d[j];
      p = p ^ d[j];
    end
    j = 1 + dl;
    if (!fm[2] || fm[1]) begin
      r[j] = p ^ bp;
      j++;
    end
    r[j] = ~bs;
    len = j + ((fm == 3'h0 || fm == 3'h1 || fm == 3'h4) ? 2 : 1);
    return r;
  endfunction

  initial begin
    rstn = 1'b0;
    bus = '{1'b0, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 8'h00};
    void'($urandom(32'hebf0_2cb7));
    repeat (3) @(posedge mclk);
    #2 rstn = 1'b1;
    `CHK({data_en, tx_line, irq_low_en, rts_n}, 4'b0100)
    ctl(8'h03);
    acc(1'b0, 1'b1, 8'h00, st);
    `CHK(st & 8'hFD, 8'h00)
    // Transmitter control codes, break last
    for (int c = 0; c < 4; c++) begin
      ctl({1'b0, c[1:0], 3'h5, 2'h0});
      repeat (4) @(posedge mclk);
      #2 `CHK(rts_n, c == 2)
      if (c == 1) `CHK(irq_low_en, 1'b1)
      if (c == 3) `CHK(tx_line, 1'b0)
    end
    ctl(8'h14);
    repeat (300) @(posedge mclk);
    #2 model.cnt = 0;
    model.frames.delete();
    model.gaps.delete();
    // Every frame format, two bytes back to back
    for (int fi = 0; fi < 8; fi++) begin
      f = fi[2:0];
      ctl({3'h0, f, 2'h0});
      d0 = 8'($urandom);
      d1 = (fi == 0) ? 8'hFF : 8'($urandom);
      e0 = frame_of(f, d0, 1'b0, 1'b0, n);
      e1 = frame_of(f, d1, 1'b0, 1'b0, n);
      model.flen = n;
      model.frames.delete();
      model.gaps.delete();
      wr(1'b1, d0);
      for (k = 0; k < 22 && tx_line !== 1'b0; k++) @(posedge mclk);
      `CHK(k < 22, 1'b1)
      wr(1'b1, d1);
      acc(1'b0, 1'b1, 8'h00, st);
      `CHK(st[1], 1'b0)
      for (k = 0; k < 3000 && model.frames.size() < 2; k++) @(posedge mclk);
      if (model.frames.size() < 2) begin
        errors++;
        close_out();
      end
      `CHK(model.frames[0], e0)
      `CHK(model.frames[1], e1)
      `CHK(model.gaps[1], 0)
      acc(1'b0, 1'b1, 8'h00, st);
      `CHK(st[1], 1'b1)
    end
    // Receive: good, parity and stop faults, seven-bit modes
    for (int i = 0; i < 5; i++) begin
      f = rx_tab[i][4:2];
      ctl({3'h0, f, 2'h0});
      d0 = 8'($urandom);
      model.send(frame_of(f, d0, rx_tab[i][1], rx_tab[i][0], n), n);
      wait_full();
      `CHK(irq_low_en, 1'b0)
      acc(1'b0, 1'b1, 8'h00, st);
      `CHK(st[6:4], {rx_tab[i][1], 1'b0, rx_tab[i][0]})
      acc(1'b1, 1'b1, 8'h00, rv);
      `CHK(rv, f[2] ? d0 : {1'b0, d0[6:0]})
      acc(1'b0, 1'b1, 8'h00, st);
      `CHK(st[0], 1'b0)
      acc(1'b1, 1'b1, 8'h00, st);
      `CHK(st, rv)
    end
    // Second character arrives unread
    ctl(8'h14);
    d0 = 8'($urandom);
    d1 = 8'($urandom);
    model.send(frame_of(3'h5, d0, 1'b0, 1'b0, n), n);
    model.send(frame_of(3'h5, d1, 1'b0, 1'b0, n), n);
    repeat (20) @(posedge mclk);
    acc(1'b0, 1'b1, 8'h00, st);
    `CHK({st[5], st[0]}, 2'b01)
    acc(1'b1, 1'b1, 8'h00, rv);
    `CHK(rv, d0)
    acc(1'b0, 1'b1, 8'h00, st);
    `CHK({st[5], st[0]}, 2'b11)
    acc(1'b1, 1'b1, 8'h00, rv);
    acc(1'b0, 1'b1, 8'h00, st);
    `CHK(st[5], 1'b0)
    // Receive interrupt
    ctl(8'h94);
    d0 = 8'($urandom);
    model.send(frame_of(3'h5, d0, 1'b0, 1'b0, n), n);
    wait_full();
    acc(1'b0, 1'b1, 8'h00, st);
    `CHK({st[7], irq_low_en}, 2'b11)
    acc(1'b1, 1'b1, 8'h00, rv);
    repeat (2) @(posedge mclk);
    #2 `CHK(irq_low_en, 1'b0)
    // Carrier loss latch and its clearing order
    model.dcd_n = 1'b1;
    repeat (4) @(posedge mclk);
    #2 `CHK(irq_low_en, 1'b1)
    acc(1'b0, 1'b1, 8'h00, st);
    `CHK({st[2], st[0]}, 2'b10)
    model.dcd_n = 1'b0;
    repeat (4) @(posedge mclk);
    acc(1'b0, 1'b1, 8'h00, st);
    `CHK(st[2], 1'b1)
    acc(1'b1, 1'b1, 8'h00, rv);
    acc(1'b0, 1'b1, 8'h00, st);
    `CHK({st[2], irq_low_en}, 2'b00)
    // Clear-to-send high hides transmit empty
    model.cts_n = 1'b1;
    repeat (4) @(posedge mclk);
    acc(1'b0, 1'b1, 8'h00, st);
    `CHK(st[3:1], 3'b100)
    model.cts_n = 1'b0;
    // Master reset clears flags, keeps other control bits
    ctl(8'h18);
    model.send(frame_of(3'h6, 8'($urandom), 1'b1, 1'b0, n), n);
    wait_full();
    ctl(8'h43);
    repeat (3) @(posedge mclk);
    acc(1'b0, 1'b1, 8'h00, st);
    `CHK({st[6:4], st[0], rts_n}, 5'b00001)
    close_out();
  end
endmodule // tb_asa_adapter
